/* trbg_top.sv */
// trbg_top: random byte generator with wishbone register slave and interrupt
// assumes a classic wishbone master on clk_i and synchronous active-high reset
// Operation
// - write 1 to start register begins generation; to stop register halts it
// - running generator produces bytes continuously, unseeded, into the output register
// - one ready event per byte written to the output register
// - corrected bits shift into an eight-bit holding register read in parallel
// - output register read-only, byte in bits 7..0, upper bits zero
// - settings bit 0 enables bias correction, slower but uniform
// - byte time varies unpredictably only with correction enabled; without it every byte takes the same time
// - auto-stop bit 0 makes each ready event trigger the stop task
// - writing 1 to enable-set bit 0 enables the ready interrupt; reads state
// - writing 1 to enable-clear bit 0 disables the ready interrupt; reads state
// - ready flag register readable and writable, bit 0 set once event occurs
// - about 128 us delay once after start before generation begins
// - without correction a byte takes about 30 us
// - with correction a byte takes about 120 us typical, unbounded
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
module trbg_top
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [11:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             irq_o
);
   typedef enum logic [1:0] {TRBG_IDLE, TRBG_WARMUP, TRBG_RUN} trbg_state_t;

   typedef struct packed
   {
      trbg_state_t state;
      logic [10:0] warm;
      logic [7:0]  shift;
      logic [2:0]  count;
      logic        pair_have;
      logic        pair_bit;
      logic [7:0]  value;
      logic        ready_flag;
      logic        auto_stop;
      logic        irq_en;
      logic        irq_status;
      logic        bias_en;
      logic [31:0] rdata;
      logic        ack;
      logic        irq;
   } trbg_top_t;

   trbg_top_t st;
   trbg_top_t next_st;
   logic      noise_bit;
   logic      noise_tick;
   logic      bus_wr;
   logic      lane0;
   logic      wbit;

   trbg_noise u_noise
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .run_i      (st.state == TRBG_RUN),
      .bit_o      (noise_bit),
      .bit_tick_o (noise_tick)
   );

   function automatic logic [31:0] trbg_bit0(input logic b);
      trbg_bit0 = {31'h0000_0000, b};
   endfunction : trbg_bit0

   assign bus_wr = cyc_i && stb_i && we_i && !st.ack;
   assign lane0  = sel_i[0];
   assign wbit   = dat_i[trbg_pkg::BIT_FIELD] && lane0;

   always_comb
   begin
      logic take_bit;
      logic corr_bit;
      logic byte_done;
      logic do_stop;
      take_bit  = 1'b0;
      corr_bit  = 1'b0;
      byte_done = 1'b0;
      do_stop   = 1'b0;
      next_st   = st;
      next_st.ack = cyc_i && stb_i && !st.ack;

      // bias correction pairs raw bits: 01 -> 0, 10 -> 1, equal pairs dropped
      if (noise_tick && st.state == TRBG_RUN)
      begin
         if (!st.bias_en)
         begin
            take_bit = 1'b1;
            corr_bit = noise_bit;
         end
         else if (!st.pair_have)
         begin
            next_st.pair_have = 1'b1;
            next_st.pair_bit  = noise_bit;
         end
         else
         begin
            next_st.pair_have = 1'b0;
            take_bit = (st.pair_bit != noise_bit);
            corr_bit = st.pair_bit;
         end
      end

      if (take_bit)
      begin
         next_st.shift = {st.shift[6:0], corr_bit};
         next_st.count = st.count + 3'h1;
         if (st.count == 3'h7)
         begin
            byte_done     = 1'b1;
            next_st.value = {st.shift[6:0], corr_bit};
         end
      end

      unique case (st.state)
         TRBG_IDLE:
         begin
            next_st.warm = trbg_pkg::START_DELAY_CNT;
         end
         TRBG_WARMUP:
         begin
            next_st.warm = st.warm - 11'h001;
            if (st.warm == 11'h001)
            begin
               next_st.state = TRBG_RUN;
            end
         end
         TRBG_RUN:
         begin
            next_st.warm = trbg_pkg::START_DELAY_CNT;
         end
      endcase

      if (byte_done && st.auto_stop)
      begin
         do_stop = 1'b1;
      end

      if (bus_wr)
      begin
         unique case (adr_i)
            trbg_pkg::OFF_START:
            begin
               if (wbit && st.state == TRBG_IDLE)
               begin
                  next_st.state     = TRBG_WARMUP;
                  next_st.count     = 3'h0;
                  next_st.pair_have = 1'b0;
               end
            end
            trbg_pkg::OFF_STOP:
            begin
               if (wbit)
               begin
                  do_stop = 1'b1;
               end
            end
            trbg_pkg::OFF_READY_FLAG:
            begin
               if (lane0)
               begin
                  next_st.ready_flag = dat_i[trbg_pkg::BIT_FIELD];
               end
            end
            trbg_pkg::OFF_AUTO_STOP:
            begin
               if (lane0)
               begin
                  next_st.auto_stop = dat_i[trbg_pkg::BIT_FIELD];
               end
            end
            trbg_pkg::OFF_IRQ_SET:
            begin
               if (wbit)
               begin
                  next_st.irq_en = 1'b1;
               end
            end
            trbg_pkg::OFF_IRQ_CLR:
            begin
               if (wbit)
               begin
                  next_st.irq_en = 1'b0;
               end
            end
            trbg_pkg::OFF_IRQ_STATUS_CLR:
            begin
               if (wbit)
               begin
                  next_st.irq_status = 1'b0;
               end
            end
            trbg_pkg::OFF_SETTINGS:
            begin
               if (lane0)
               begin
                  next_st.bias_en = dat_i[trbg_pkg::BIT_FIELD];
               end
            end
            default:
            begin
               next_st.state = st.state;
            end
         endcase
      end

      if (do_stop)
      begin
         next_st.state     = TRBG_IDLE;
         next_st.pair_have = 1'b0;
      end

      // hardware set wins over a same-cycle software clear
      if (byte_done)
      begin
         next_st.ready_flag = 1'b1;
         next_st.irq_status = 1'b1;
      end

      unique case (adr_i)
         trbg_pkg::OFF_READY_FLAG:     next_st.rdata = trbg_bit0(st.ready_flag);
         trbg_pkg::OFF_AUTO_STOP:      next_st.rdata = trbg_bit0(st.auto_stop);
         trbg_pkg::OFF_IRQ_SET:        next_st.rdata = trbg_bit0(st.irq_en);
         trbg_pkg::OFF_IRQ_CLR:        next_st.rdata = trbg_bit0(st.irq_en);
         trbg_pkg::OFF_IRQ_STATUS:     next_st.rdata = trbg_bit0(st.irq_status);
         trbg_pkg::OFF_SETTINGS:       next_st.rdata = trbg_bit0(st.bias_en);
         trbg_pkg::OFF_OUTPUT:         next_st.rdata = {24'h00_0000, st.value};
         default:                      next_st.rdata = 32'h0000_0000;
      endcase

      next_st.irq = st.irq_en && st.ready_flag;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st       <= '0;
         st.state <= TRBG_IDLE;
         st.value <= trbg_pkg::OUTPUT_RESET;
         st.warm  <= trbg_pkg::START_DELAY_CNT;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign dat_o = st.rdata;
   assign ack_o = st.ack;
   assign irq_o = st.irq;
endmodule : trbg_top

/* trbg_pkg.sv */
// trbg_pkg: register map, field positions, reset values and timing counts
// assumes a 10 MHz system clock and a 32-bit classic wishbone register bus
package trbg_pkg;
   localparam int unsigned CLK_HZ                = 10_000_000;
   localparam logic [11:0] OFF_START             = 12'h000;
   localparam logic [11:0] OFF_STOP              = 12'h004;
   localparam logic [11:0] OFF_READY_FLAG        = 12'h100;
   localparam logic [11:0] OFF_AUTO_STOP         = 12'h200;
   localparam logic [11:0] OFF_IRQ_SET           = 12'h304;
   localparam logic [11:0] OFF_IRQ_CLR           = 12'h308;
   localparam logic [11:0] OFF_IRQ_STATUS        = 12'h30c;
   localparam logic [11:0] OFF_IRQ_STATUS_CLR    = 12'h310;
   localparam logic [11:0] OFF_SETTINGS          = 12'h504;
   localparam logic [11:0] OFF_OUTPUT            = 12'h508;
   localparam int unsigned BIT_FIELD             = 0;
   localparam logic [7:0]  OUTPUT_RESET          = 8'h00;
   localparam logic [15:0] LFSR_SEED             = 16'hace1;
   localparam int unsigned START_DELAY_NS        = 128_000;
   localparam int unsigned BYTE_RAW_NS           = 30_000;
   localparam int unsigned BYTE_BC_NS            = 120_000;
   localparam int unsigned START_DELAY_CYC       = START_DELAY_NS / (1_000_000_000 / CLK_HZ);
   localparam int unsigned RAW_BIT_CYC           = BYTE_RAW_NS / (1_000_000_000 / CLK_HZ) / 8;
   localparam logic [10:0] START_DELAY_CNT       = 11'(START_DELAY_CYC);
   localparam logic [8:0]  RAW_BIT_CNT           = 9'(RAW_BIT_CYC);
endpackage : trbg_pkg

/* trbg_noise.sv */
// trbg_noise: stand-in noise source, one raw bit per bit_tick_o pulse while run_i is high
// assumes clk_i at 10 MHz; bit_tick_o paces raw bits at one per 37 clocks, eight per raw byte time
`timescale 1ns/1ps
module trbg_noise
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic run_i,
   output logic      bit_o,
   output logic      bit_tick_o
);
   typedef struct packed
   {
      logic [15:0] lfsr;
      logic [8:0]  div;
      logic        bit_q;
      logic        tick;
   } trbg_noise_t;

   trbg_noise_t st;
   trbg_noise_t next_st;

   always_comb
   begin
      next_st      = st;
      next_st.tick = 1'b0;
      next_st.lfsr = {st.lfsr[14:0], st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10]};
      if (run_i)
      begin
         if (st.div == 9'h000)
         begin
            next_st.div   = trbg_pkg::RAW_BIT_CNT - 9'h001;
            next_st.tick  = 1'b1;
            next_st.bit_q = st.lfsr[0];
         end
         else
         begin
            next_st.div = st.div - 9'h001;
         end
      end
      else
      begin
         next_st.div = trbg_pkg::RAW_BIT_CNT - 9'h001;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st      <= '0;
         st.lfsr <= trbg_pkg::LFSR_SEED;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign bit_o      = st.bit_q;
   assign bit_tick_o = st.tick;
endmodule : trbg_noise

/* trbg_assertions.sv */
// trbg_assertions: bus answer, register read and interrupt checks
// assumes a bind onto trbg_top; one clock, synchronous reset
`timescale 1ns/1ps
module trbg_assertions
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [11:0] adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        irq_o
);
   logic en;
   logic rd;
   logic tk;
   assign rd = ack_o && !we_i;
   assign tk = cyc_i && stb_i && !ack_o && we_i && sel_i[0] && dat_i[0];
   // mirror of the interrupt enable, updated on the taking edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         en <= 1'b0;
      else if (tk && adr_i == trbg_pkg::OFF_IRQ_SET)
         en <= 1'b1;
      else if (tk && adr_i == trbg_pkg::OFF_IRQ_CLR)
         en <= 1'b0;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_answers: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("no ack one cycle after request");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_output_byte: assert property (rd && adr_i == trbg_pkg::OFF_OUTPUT |-> dat_o[31:8] == 24'h0)
      else $error("output upper bits not zero");
   a_flag_bit: assert property (rd && adr_i == trbg_pkg::OFF_READY_FLAG |-> dat_o[31:1] == 31'h0)
      else $error("ready flag upper bits not zero");
   a_enable_read: assert property (rd && (adr_i == trbg_pkg::OFF_IRQ_SET ||
      adr_i == trbg_pkg::OFF_IRQ_CLR) |-> dat_o == {31'h0, en})
      else $error("enable read wrong");
   a_irq_enabled: assert property (irq_o |-> $past(en))
      else $error("interrupt while disabled");
   a_irq_cleared: assert property (tk && adr_i == trbg_pkg::OFF_IRQ_CLR |=> ##1 !irq_o)
      else $error("interrupt after disable");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o && dat_o == 32'h0)
      else $error("outputs active in reset");
   c_start: cover property (tk && adr_i == trbg_pkg::OFF_START);
   c_irq: cover property ($rose(irq_o));
   c_output: cover property (rd && adr_i == trbg_pkg::OFF_OUTPUT);
endmodule : trbg_assertions

/* tb_top.sv */
// tb_top: register-level tests of the random byte generator
// assumes trbg_top with a one-cycle wishbone answer at 10 MHz
`timescale 1ns/1ps
module tb_top;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
   logic [11:0] adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, rd, v;
   int          err_total, checks, n, m;
   logic [11:0] ra[7] = '{12'h100, 12'h200, 12'h304, 12'h308, 12'h504, 12'h508, 12'h0fc};
   trbg_top i_trbg_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .irq_o(irq_o));
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task check(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         err_total++;
         $display("unexpected at %0t: %h expected %h", $time, s, e);
      end
   endtask : check
   task wrap_up;
      if (err_total == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   // one classic cycle; ack and read data taken at the rising edge that sees ack high
   task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(negedge clk_i);
   endtask : acc
   task wait_irq;
      n = 0;
      while (irq_o !== 1'b1 && n < 20000)
      begin
         @(negedge clk_i);
         n++;
      end
   endtask : wait_irq
   initial
   begin
      repeat (80000) @(posedge clk_i);
      err_total++;
      wrap_up;
   end
   initial
   begin
      {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {4'h8, 48'h0};
      {err_total, checks} = 0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ra[i])
      begin
         acc(0, ra[i], 0);
         check(rd, 0);
      end
      acc(1, 12'h0fc, 32'hffffffff);
      acc(0, 12'h0fc, 0);
      check(rd, 0);
      acc(1, 12'h200, 1);
      acc(0, 12'h200, 0);
      check(rd, 1);
      acc(1, 12'h504, 1);
      acc(0, 12'h504, 0);
      check(rd, 1);
      acc(1, 12'h200, 0);
      acc(1, 12'h504, 0);
      acc(1, 12'h304, 0);
      acc(0, 12'h308, 0);
      check(rd, 0);
      acc(1, 12'h304, 1);
      acc(0, 12'h308, 0);
      check(rd, 1);
      acc(1, 12'h308, 0);
      acc(0, 12'h304, 0);
      check(rd, 1);
      acc(1, 12'h308, 1);
      acc(0, 12'h304, 0);
      check(rd, 0);
      acc(1, 12'h304, 1);
      acc(1, 12'h000, 1);
      wait_irq;
      check(32'(n >= 1270 && n < 1700), 1);
      acc(0, 12'h508, 0);
      check(rd >> 8, 0);
      acc(1, 12'h100, 0);
      check(irq_o, 0);
      wait_irq;
      check(32'(n >= 200 && n < 350), 1);
      acc(1, 12'h308, 1);
      m = 0;
      do acc(0, 12'h100, 0); while (rd !== 1 && m++ < 200);
      check(rd, 1);
      check(irq_o, 0);
      acc(1, 12'h304, 1);
      check(irq_o, 1);
      acc(1, 12'h004, 1);
      acc(1, 12'h100, 0);
      repeat (800) @(negedge clk_i);
      check(irq_o, 0);
      acc(0, 12'h508, 0);
      v = rd;
      acc(1, 12'h508, 32'h5a);
      acc(0, 12'h508, 0);
      check(rd, v);
      acc(1, 12'h200, 1);
      acc(1, 12'h000, 1);
      wait_irq;
      check(32'(n >= 1270 && n < 1700), 1);
      acc(1, 12'h100, 0);
      repeat (800) @(negedge clk_i);
      check(irq_o, 0);
      acc(1, 12'h200, 0);
      acc(1, 12'h504, 1);
      acc(1, 12'h000, 1);
      wait_irq;
      acc(1, 12'h100, 0);
      wait_irq;
      check(32'(n >= 585 && n < 20000), 1);
      check(irq_o, 1);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      acc(0, 12'h504, 0);
      check(rd, 0);
      wrap_up;
   end
endmodule : tb_top
bind trbg_top trbg_assertions i_trbg_assertions (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
   .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));
